// ==== rtl/dr_recorder.sv ====
`timescale 1ns/1ps
`include "dr_regs.svh"
//==============================================================
// Behaviour
// [R1] stage start/trip or digital input can trigger a recording
// [R2] per-source routing bit selects which sources trigger
// [R3] manual command triggers like a hardware source
// [R4] each recording stamped with system time at trigger
// [R5] store holds at most twelve recordings
// [R6] append beyond twelve channels is refused
// [R7] all digital inputs packed into one channel
// [R8] all digital outputs packed into one channel
// [R9] arc flags join the input word when arc hardware fitted
// [R10] saturate mode: full store rejects triggers, keeps data
// [R11] overwrite mode: full store replaces oldest recording
// [R12] set percentage of length is pre-trigger samples
// [R13] maximum length computed from rate and channels, read-only; code uses channel count only
// [R14] status: idle, armed, recording, full in saturate
// [R15] available and maximum recording counts reported
// [R16] each append adds exactly one channel, up to twelve
// [R17] selected channel list is readable
// [R18] 10 ms rate stores one-cycle rms refreshed each 10 ms
// [R19] 20 ms rate stores one-cycle rms refreshed each 20 ms
// [R20] setting writes accepted only with password authorised
// [R21] recordings exportable in COMTRADE layout by readout
// [R22] armed recorder writes pre-trigger samples continuously
module dr_recorder
    import dr_pkg::*;
#(
    parameter int NSRC    = 16,
    parameter int NDI     = 8,
    parameter int NDO     = 8,
    parameter int NAN     = 32,
    parameter int AW      = 12,
    parameter int CLK_KHZ = 200000
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 clkEn,
    // trigger sources
    input  wire logic [NSRC-1:0]      stageStartTrip,
    input  wire logic [NDI-1:0]       digitalIn,
    input  wire logic [NDO-1:0]       digitalOut,
    input  wire logic [NSRC+NDI-1:0]  recorderTriggerColumn,
    input  wire logic                 manualTriggerCmd,
    // arc option
    input  wire logic                 arcFitted,
    input  wire logic                 arcSensorA,
    input  wire logic                 arcSensorB,
    input  wire logic                 arcBinaryIn,
    input  wire logic                 arcBinaryOut,
    // measurements
    input  wire logic [NAN-1:0][15:0] measValue,
    input  wire logic                 cycleStrobe,
    input  wire logic [31:0]          systemTime,
    // settings
    input  wire logic                 passwordOk,
    input  wire logic                 cfgWrite,
    input  wire dr_cfg_t              cfgIn,
    input  wire logic                 enableRecorder,
    input  wire logic                 appendChannelCmd,
    input  wire logic                 clearChannelsCmd,
    input  wire logic [5:0]           channelSel,
    // readout
    input  wire logic [3:0]           readRec,
    input  wire logic [AW-1:0]        readAddr,
    output logic [15:0]               readData,
    output dr_rec_t                   readHeader,
    // status
    output logic [1:0]                recorderStatus,
    output logic [3:0]                recordingsAvailable,
    output logic [3:0]                recordingsMax,
    output logic [15:0]               maxLengthLimit,
    output logic [`DR_MAX_CHANNELS-1:0][5:0] channelListOut,
    output logic                      appendRefused
);
    localparam int DEPTH = 1 << AW;

    initial begin
        if (AW < 6 || AW > 16) $error("AW out of range");
        if (NDI + 4 > 16 || NDO > 16) $error("packed word too wide");
        if (NAN > 62) $error("NAN collides with packed codes");
    end

    //==========================================================
    // synchronisers for pin-level inputs
    logic [NSRC+NDI+5:0] s1_q, s2_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
        end else if (clkEn) begin
            s1_q <= {arcSensorA, arcSensorB, arcBinaryIn, arcBinaryOut, manualTriggerCmd,
                     cycleStrobe, digitalIn, stageStartTrip};
            s2_q <= s1_q;
        end
    end
    logic [NSRC-1:0] stageS;
    logic [NDI-1:0]  diS;
    logic            cycS, manS;
    logic [3:0]      arcS;
    assign stageS = s2_q[NSRC-1:0];
    assign diS    = s2_q[NSRC+NDI-1:NSRC];
    assign cycS   = s2_q[NSRC+NDI];
    assign manS   = s2_q[NSRC+NDI+1];
    assign arcS   = s2_q[NSRC+NDI+5:NSRC+NDI+2];

    //==========================================================
    // settings, guarded by authorisation
    dr_cfg_t cfg_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= '0;
        end else if (clkEn && cfgWrite && passwordOk) begin // [R20]
            cfg_q <= cfgIn;
        end
    end

    //==========================================================
    // channel list and sample tick
    logic [3:0] chanCount;
    logic       sampleTick;
    dr_chan_list #(.NCH(`DR_MAX_CHANNELS)) uList (
        .ref_clk          (ref_clk),
        .rst_b            (rst_b),
        .clkEn            (clkEn),
        .appendChannelCmd (appendChannelCmd),
        .clearChannelsCmd (clearChannelsCmd),
        .channelSel       (channelSel),
        .writeAllowed     (passwordOk), // [R20]
        .channelList      (channelListOut),
        .channelCount     (chanCount),
        .appendRefused    (appendRefused)
    );
    dr_tick_gen #(.CLK_KHZ(CLK_KHZ)) uTick (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .clkEn       (clkEn),
        .rate        (cfg_q.rate),
        .cycleStrobe (cycS),
        .sampleTick  (sampleTick)
    );

    //==========================================================
    // trigger: routed sources or manual, rising edge only
    logic trigLvl, trigPrev_q, trigEdge;
    assign trigLvl  = (|({diS, stageS} & recorderTriggerColumn)) || manS; // [R1] [R2] [R3]
    assign trigEdge = trigLvl && !trigPrev_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) trigPrev_q <= 1'b0;
        else if (clkEn) trigPrev_q <= trigLvl;
    end

    //==========================================================
    // sample word per channel slot
    function automatic logic [15:0] chanWord(input logic [5:0] code);
        logic [15:0] w;
        w = 16'h0;
        if (code == `DR_SRC_DI) begin
            w[NDI-1:0] = diS; // [R7]
            if (arcFitted) w[NDI+3:NDI] = arcS; // [R9]
        end else if (code == `DR_SRC_DO) begin
            w[NDO-1:0] = digitalOut; // [R8]
        end else if (code < 6'(NAN)) begin
            w = measValue[code];
        end
        return w;
    endfunction

    //==========================================================
    // capacity figures
    logic [AW-1:0] perRec;
    logic [AW:0]   lenClip;
    logic [3:0]    maxRecs;
    logic [AW:0]   samplesPerRec;
    always_comb begin
        samplesPerRec = (chanCount == 4'h0) ? (AW+1)'(DEPTH) : (AW+1)'(DEPTH) / (AW+1)'(chanCount);
        lenClip = (cfg_q.lengthSamples > 16'(samplesPerRec)) ? samplesPerRec
                                                             : (AW+1)'(cfg_q.lengthSamples);
        maxRecs = (lenClip == '0) ? 4'h1 :
                  ((samplesPerRec / lenClip) > (AW+1)'(`DR_MAX_RECORDINGS)) ? 4'(`DR_MAX_RECORDINGS)
                  : ((samplesPerRec / lenClip) == '0 ? 4'h1 : 4'(samplesPerRec / lenClip)); // [R5] [R15]
        perRec = AW'(lenClip * (AW+1)'(chanCount == 4'h0 ? 4'h1 : chanCount));
    end

    //==========================================================
    // storage, flip-flops addressed by index
    logic [15:0] mem_q [DEPTH];
    dr_rec_t     hdr_q [`DR_MAX_RECORDINGS];
    dr_state_t   state_q;
    logic [3:0]  slot_q, oldest_q, count_q, chIdx_q;
    logic [AW-1:0] wrPtr_q, base_q;
    logic [15:0] postLeft_q, preCnt_q;
    logic [15:0] preNeed;
    assign preNeed = 16'((32'(lenClip) * 32'(cfg_q.preTrigPct)) / 32'(`DR_PCT_FULL)); // [R12]

    // per-sample write walks channel slots, one per clock
    logic writing;
    assign writing = (state_q == DR_ARMED || state_q == DR_REC) && (chIdx_q != 4'h0 || sampleTick);
    always_ff @(posedge ref_clk) begin
        if (clkEn && writing && chanCount != 4'h0) begin
            mem_q[base_q + AW'(wrPtr_q) + AW'(chIdx_q)] <= chanWord(channelListOut[chIdx_q]); // [R22]
        end
    end

    // recorder sequence
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= DR_IDLE;
            slot_q     <= 4'h0;
            oldest_q   <= 4'h0;
            count_q    <= 4'h0;
            chIdx_q    <= 4'h0;
            wrPtr_q    <= '0;
            base_q     <= '0;
            postLeft_q <= 16'h0;
            preCnt_q   <= 16'h0;
            for (int i = 0; i < `DR_MAX_RECORDINGS; i++) hdr_q[i] <= '0;
        end else if (clkEn) begin
            if (writing && chanCount != 4'h0) begin
                chIdx_q <= (chIdx_q + 4'h1 >= chanCount) ? 4'h0 : chIdx_q + 4'h1;
                if (chIdx_q + 4'h1 >= chanCount) begin
                    wrPtr_q <= (wrPtr_q + AW'(chanCount) >= perRec) ? '0 : wrPtr_q + AW'(chanCount); // [R22]
                    if (state_q == DR_ARMED && preCnt_q < preNeed) preCnt_q <= preCnt_q + 16'h1;
                    if (state_q == DR_REC) postLeft_q <= postLeft_q - 16'h1;
                end
            end
            // disarm clears the store, so a later arm starts empty
            if (!enableRecorder && state_q != DR_REC) begin
                count_q  <= 4'h0;
                slot_q   <= 4'h0;
                oldest_q <= 4'h0;
            end
            case (state_q)
                DR_IDLE: begin
                    if (enableRecorder && chanCount != 4'h0) begin
                        state_q  <= DR_ARMED;
                        base_q   <= AW'(perRec * AW'(slot_q));
                        preCnt_q <= 16'h0;
                        wrPtr_q  <= '0;
                    end
                end
                DR_ARMED: begin
                    if (!enableRecorder) begin
                        state_q <= DR_IDLE;
                    end else if (trigEdge) begin // [R1] [R3]
                        state_q <= DR_REC;
                        postLeft_q <= 16'(lenClip) - preCnt_q; // [R12]
                        hdr_q[slot_q].stamp    <= systemTime; // [R4]
                        hdr_q[slot_q].startPtr <= 16'(wrPtr_q);
                        hdr_q[slot_q].channels <= chanCount;
                    end
                end
                DR_REC: begin
                    if (postLeft_q == 16'h0) begin
                        slot_q <= (slot_q + 4'h1 >= maxRecs) ? 4'h0 : slot_q + 4'h1;
                        if (count_q < maxRecs) begin
                            count_q <= count_q + 4'h1;
                        end else begin
                            oldest_q <= (oldest_q + 4'h1 >= maxRecs) ? 4'h0 : oldest_q + 4'h1; // [R11]
                        end
                        if (count_q + 4'h1 >= maxRecs && cfg_q.saturate) begin
                            state_q <= DR_FULL; // [R10]
                        end else begin
                            state_q <= DR_IDLE; // re-arms next cycle
                        end
                    end
                end
                DR_FULL: begin
                    if (!enableRecorder) state_q <= DR_IDLE;
                end
                default: state_q <= DR_IDLE;
            endcase
        end
    end

    //==========================================================
    // registered status and readout
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            recorderStatus      <= `DR_ST_IDLE;
            recordingsAvailable <= 4'h0;
            recordingsMax       <= 4'h0;
            maxLengthLimit      <= 16'h0;
            readData            <= 16'h0;
            readHeader          <= '0;
        end else if (clkEn) begin
            recorderStatus      <= state_q; // [R14]
            recordingsAvailable <= count_q; // [R15]
            recordingsMax       <= maxRecs;
            maxLengthLimit      <= 16'(samplesPerRec); // [R13]
            readData            <= mem_q[readAddr]; // [R21]
            readHeader          <= hdr_q[(readRec >= 4'(`DR_MAX_RECORDINGS)) ? 4'h0 : readRec];
        end
    end
endmodule // dr_recorder

// ==== common/dr_regs.svh ====
`ifndef DR_REGS_SVH
`define DR_REGS_SVH
// channel and recording limits
`define DR_MAX_CHANNELS    12
`define DR_MAX_RECORDINGS  12
// digital source codes select packed words; lower codes are analogue
`define DR_SRC_DI          6'h3e
`define DR_SRC_DO          6'h3f
// sample-rate codes, table order
`define DR_SR_32           4'h0
`define DR_SR_16           4'h1
`define DR_SR_8            4'h2
`define DR_SR_10MS         4'h3
`define DR_SR_20MS         4'h4
// one-cycle refresh periods
`define DR_T10_MS          10
`define DR_T20_MS          20
// status codes
`define DR_ST_IDLE         2'h0
`define DR_ST_ARMED        2'h1
`define DR_ST_REC          2'h2
`define DR_ST_FULL         2'h3
// percent full scale
`define DR_PCT_FULL        7'h64
`endif

// ==== common/dr_pkg.sv ====
package dr_pkg;
    typedef enum logic [1:0] {
        DR_IDLE  = 2'b00,
        DR_ARMED = 2'b01,
        DR_REC   = 2'b10,
        DR_FULL  = 2'b11
    } dr_state_t;

    typedef struct packed {
        logic       saturate;
        logic [3:0] rate;
        logic [6:0] preTrigPct;
        logic [15:0] lengthSamples;
    } dr_cfg_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [15:0] startPtr;
        logic [3:0]  channels;
    } dr_rec_t;
endpackage

// ==== rtl/dr_chan_list.sv ====
`timescale 1ns/1ps
`include "dr_regs.svh"
module dr_chan_list
    import dr_pkg::*;
#(
    parameter int NCH = `DR_MAX_CHANNELS
) (
    // clock
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               clkEn,
    // commands
    input  wire logic               appendChannelCmd,
    input  wire logic               clearChannelsCmd,
    input  wire logic [5:0]         channelSel,
    input  wire logic               writeAllowed,
    // list
    output logic [NCH-1:0][5:0]     channelList,
    output logic [3:0]              channelCount,
    output logic                    appendRefused
);
    initial begin
        if (NCH < 1 || NCH > 15) $error("NCH out of range");
    end

    // list fills from slot 0; one slot per append
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            channelList   <= '0;
            channelCount  <= 4'h0;
            appendRefused <= 1'b0;
        end else if (clkEn) begin
            appendRefused <= 1'b0;
            if (writeAllowed && clearChannelsCmd) begin
                channelCount <= 4'h0;
            end else if (writeAllowed && appendChannelCmd) begin
                if (channelCount < 4'(NCH)) begin // [R16]
                    channelList[channelCount] <= channelSel; // [R17]
                    channelCount <= channelCount + 4'h1;
                end else begin
                    appendRefused <= 1'b1; // [R6]
                end
            end
        end
    end
endmodule // dr_chan_list

// ==== rtl/dr_tick_gen.sv ====
`timescale 1ns/1ps
`include "dr_regs.svh"
module dr_tick_gen #(
    parameter int CLK_KHZ = 200000
) (
    // clock
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    // rate
    input  wire logic [3:0] rate,
    input  wire logic       cycleStrobe,
    // tick
    output logic            sampleTick
);
    localparam int C10 = `DR_T10_MS * CLK_KHZ;
    localparam int C20 = `DR_T20_MS * CLK_KHZ;
    logic [31:0] cnt_q;
    logic [31:0] lim;

    initial begin
        if (CLK_KHZ < 1) $error("CLK_KHZ too small");
    end

    // one-cycle rates count real time; waveform rates follow the sampler
    always_comb begin
        lim = (rate == `DR_SR_20MS) ? 32'(C20 - 1) : 32'(C10 - 1); // [R18] [R19]
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q      <= 32'h0;
            sampleTick <= 1'b0;
        end else if (clkEn) begin
            if (rate == `DR_SR_10MS || rate == `DR_SR_20MS) begin
                sampleTick <= (cnt_q >= lim);
                cnt_q      <= (cnt_q >= lim) ? 32'h0 : cnt_q + 32'h1;
            end else begin
                sampleTick <= cycleStrobe;
                cnt_q      <= 32'h0;
            end
        end
    end
endmodule // dr_tick_gen

// ==== tb/dr_recorder_assertions.sv ====
`timescale 1ns/1ps
`include "dr_regs.svh"
//==============================================================
// recorder port checker
module dr_checker (
    // clock and reset
    input wire logic                          ref_clk,
    input wire logic                          rst_b,
    input wire logic                          clkEn,
    // commands
    input wire logic                          enableRecorder,
    input wire logic                          passwordOk,
    input wire logic                          appendChannelCmd,
    // status
    input wire logic [1:0]                    recorderStatus,
    input wire logic [3:0]                    recordingsAvailable,
    input wire logic [3:0]                    recordingsMax,
    input wire logic [`DR_MAX_CHANNELS-1:0][5:0] channelListOut,
    input wire logic                          appendRefused
);
    // single clock domain
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_refuse_cause: assert property (appendRefused |-> $past(appendChannelCmd && passwordOk))
        else $error("stray refusal");
    a_refuse_keeps: assert property (appendRefused |-> $stable(channelListOut))
        else $error("list moved on refusal");
    a_store_cap: assert property (recordingsAvailable <= `DR_MAX_RECORDINGS)
        else $error("store over limit");
    a_full_count: assert property (recorderStatus == `DR_ST_FULL |-> recordingsAvailable == recordingsMax)
        else $error("full below max");
    a_full_hold: assert property (recorderStatus == `DR_ST_FULL && enableRecorder && clkEn |=> $stable(recordingsAvailable))
        else $error("full count moved");
    a_disarm_idle: assert property ($fell(enableRecorder) |-> ##[1:3] recorderStatus == `DR_ST_IDLE && recordingsAvailable == 4'h0)
        else $error("disarm not cleared");
    a_count_step: assert property (enableRecorder && $past(enableRecorder) && $changed(recordingsAvailable) |-> recordingsAvailable == $past(recordingsAvailable) + 4'h1)
        else $error("count step not one");
    a_no_auth: assert property (!$past(passwordOk) && !passwordOk |-> $stable(channelListOut))
        else $error("unauthorised list change");
    a_rec_armed: assert property ($rose(recorderStatus == `DR_ST_REC) |-> $past(recorderStatus) == `DR_ST_ARMED)
        else $error("recording not from armed");
endmodule // dr_checker

bind dr_recorder dr_checker dr_checker_inst (.ref_clk, .rst_b, .clkEn, .enableRecorder, .passwordOk,
    .appendChannelCmd, .recorderStatus, .recordingsAvailable, .recordingsMax, .channelListOut, .appendRefused);

// ==== tb/dr_source_model.sv ====
`timescale 1ns/1ps
//==============================================================
// protection stages, cycle strobe, time base and measurements
module dr_source_model #(
    parameter int NSRC = 16,
    parameter int NAN  = 32,
    parameter int DIV  = 4
) (
    // clock
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // stage requests from the bench
    input  wire logic [NSRC-1:0]      stageReq,
    // sources
    output logic [NSRC-1:0]           stageStartTrip,
    output logic                      cycleStrobe,
    output logic [31:0]               systemTime,
    output logic [NAN-1:0][15:0]      measValue
);
    int divQ;

    // falling-edge drive, clear of the sampling edge
    always @(negedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {stageStartTrip, cycleStrobe, systemTime, measValue} <= '0;
            divQ <= 0;
        end else begin
            systemTime <= systemTime + 32'h1;
            divQ <= (divQ == DIV - 1) ? 0 : divQ + 1;
            cycleStrobe <= (divQ == 0);
            stageStartTrip <= stageReq; // stage start or trip level
            for (int i = 0; i < NAN; i++) measValue[i] <= systemTime[15:0] + 16'(i);
        end
    end
endmodule // dr_source_model

// ==== tb/tb_dr_recorder.sv ====
`timescale 1ns/1ps
`include "dr_regs.svh"
module tb_dr_recorder;
    import dr_pkg::*;
    localparam int NSRC = 16, NDI = 8, NDO = 8, NAN = 32, CLK_KHZ = 10;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic manualTriggerCmd, passwordOk, cfgWrite, enableRecorder, appendChannelCmd, clearChannelsCmd;
    logic [NSRC-1:0] stageReq, stageStartTrip;
    logic [NDI-1:0] digitalIn;
    logic [NDO-1:0] digitalOut = '0;
    logic [4:0] arcV = '0;
    logic [NSRC+NDI-1:0] column;
    logic [NAN-1:0][15:0] measValue;
    logic cycleStrobe, appendRefused, ok;
    logic [31:0] systemTime, t0, lfsrQ = 32'ha820fe7f;
    dr_cfg_t cfgIn;
    dr_rec_t readHeader;
    logic [5:0] channelSel;
    logic [3:0] readRec, recordingsAvailable, recordingsMax;
    logic [15:0] readData, maxLengthLimit, lim1;
    logic [1:0] recorderStatus;
    logic [`DR_MAX_CHANNELS-1:0][5:0] channelListOut;
    int mismatches = 0, cmp_count = 0, availM = 0, n, tl;

    //==============================================================
    // clock, sources and design
    always #2.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random output word and arc flags
    always @(negedge ref_clk) begin
        lfsrQ <= lfsr(lfsrQ);
        digitalOut <= lfsrQ[7:0];
        arcV <= lfsrQ[12:8];
    end
    dr_source_model #(.NSRC(NSRC), .NAN(NAN), .DIV(4)) dr_source_model_inst (.ref_clk, .rst_b, .stageReq,
        .stageStartTrip, .cycleStrobe, .systemTime, .measValue);
    dr_recorder #(.CLK_KHZ(CLK_KHZ)) dr_recorder_inst (.ref_clk, .rst_b, .clkEn(1'b1), .stageStartTrip,
        .digitalIn, .digitalOut, .recorderTriggerColumn(column), .manualTriggerCmd, .arcFitted(arcV[0]),
        .arcSensorA(arcV[1]), .arcSensorB(arcV[2]), .arcBinaryIn(arcV[3]), .arcBinaryOut(arcV[4]),
        .measValue, .cycleStrobe, .systemTime, .passwordOk, .cfgWrite, .cfgIn, .enableRecorder,
        .appendChannelCmd, .clearChannelsCmd, .channelSel, .readRec, .readAddr('0), .readData, .readHeader,
        .recorderStatus, .recordingsAvailable, .recordingsMax, .maxLengthLimit, .channelListOut, .appendRefused);

    //==============================================================
    // shared tasks
    task automatic tick(input int k = 1);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chkV(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, m, got, exp);
        end
    endtask
    task automatic fail(input string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
        conclude();
    endtask
    // refused triggers watched briefly
    task automatic waitSt(input logic [1:0] s, input bit must, output logic got);
        got = 1'b0;
        for (int i = 0; i < (must ? 200 : 40) && !got; i++) begin
            tick();
            got = (recorderStatus === s);
        end
        if (must && !got) fail("status wait timed out");
    endtask
    // reconfigure disarmed, then let pre-trigger fill
    task automatic setCfg(input logic sat, input logic [3:0] r);
        enableRecorder = 1'b0;
        tick(4);
        chkV(recordingsAvailable, 0, "store cleared");
        cfgIn = '{saturate: sat, rate: r, preTrigPct: 7'h32, lengthSamples: 16'h0008};
        cfgWrite = 1'b1;
        passwordOk = 1'b1;
        tick();
        {cfgWrite, passwordOk, enableRecorder} = 3'h1;
        waitSt(`DR_ST_ARMED, 1'b1, ok);
        tick(1000);
        availM = 0;
    endtask
    // k: 0 manual, 1 stage 3, else input 2; n = cycles recording
    task automatic fire(input int k, input bit must, output logic got);
        t0 = systemTime;
        n = 0;
        case (k)
            0: manualTriggerCmd = 1'b1;
            1: stageReq[3] = 1'b1;
            default: digitalIn[2] = 1'b1;
        endcase
        waitSt(`DR_ST_REC, must, got);
        {manualTriggerCmd, stageReq, digitalIn} = '0;
        while (got && recorderStatus === `DR_ST_REC && n < 5000) begin
            tick();
            n++;
        end
        if (n == 5000) fail("recording never ends");
        tick();
    endtask

    //==============================================================
    // main sequence
    initial begin
        {manualTriggerCmd, passwordOk, cfgWrite, enableRecorder, appendChannelCmd, clearChannelsCmd} = '0;
        {stageReq, digitalIn, column, channelSel, readRec, cfgIn} = '0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst_b = 1'b1;
        tick();
        chkV(recorderStatus, `DR_ST_IDLE, "status after reset");
        chkV(recordingsAvailable, 0, "count after reset");
        channelSel = `DR_SRC_DI;
        appendChannelCmd = 1'b1;
        tick();
        appendChannelCmd = 1'b0;
        tick();
        chkV(channelListOut[0], 0, "unauthorised append");
        {passwordOk, appendChannelCmd} = 2'h3;
        tick();
        appendChannelCmd = 1'b0;
        tick(2);
        lim1 = maxLengthLimit;
        chkV(channelListOut[0], `DR_SRC_DI, "single append");
        {clearChannelsCmd, appendChannelCmd} = 2'h3;
        tick();
        {clearChannelsCmd, appendChannelCmd} = 2'h0;
        tick();
        chkV(channelListOut[1], 0, "clear beats append");
        // thirteen appends, last refused
        for (int i = 0; i < 13; i++) begin
            channelSel = (i == 0) ? `DR_SRC_DI : (i == 1) ? `DR_SRC_DO : {1'b0, lfsrQ[4:0]};
            appendChannelCmd = 1'b1;
            tick();
            if (i < 12) chkV(channelListOut[i], channelSel, "list entry");
            chkV(appendRefused, i == 12, "refusal pulse");
        end
        {appendChannelCmd, passwordOk} = 2'h0;
        tick(2);
        chkV(maxLengthLimit <= lim1 && maxLengthLimit != 0, 1, "length limit");
        $display("test channels done");
        setCfg(1'b1, `DR_SR_32);
        fire(0, 1'b1, ok);
        availM++;
        tick(2);
        chkV(readHeader.stamp >= t0 && readHeader.stamp <= t0 + 32'h14, 1, "time stamp");
        chkV(readHeader.channels, 12, "packed channels");
        chkV(recordingsAvailable, availM, "manual trigger");
        fire(1, 1'b0, ok);
        chkV(ok, 0, "unrouted stage");
        column[3] = 1'b1;
        column[NSRC+2] = 1'b1;
        fire(1, 1'b1, ok);
        availM++;
        chkV(recordingsAvailable, availM, "routed stage");
        fire(2, 1'b1, ok);
        availM++;
        chkV(recordingsAvailable, availM, "digital input");
        while (availM < recordingsMax && availM < 12) begin
            fire(0, 1'b1, ok);
            availM++;
        end
        chkV(recordingsAvailable, availM, "store filled");
        chkV(recorderStatus, `DR_ST_FULL, "full status");
        fire(0, 1'b0, ok);
        chkV(ok, 0, "trigger when full");
        chkV(recordingsAvailable, availM, "kept recordings");
        $display("test saturate done");
        setCfg(1'b0, `DR_SR_32);
        for (int i = 0; i <= recordingsMax; i++) begin
            fire(0, 1'b1, ok);
            availM = (availM < recordingsMax) ? availM + 1 : availM;
        end
        chkV(recordingsAvailable, availM, "overwrite count");
        chkV(recorderStatus, `DR_ST_ARMED, "overwrite stays armed");
        $display("test overwrite done");
        // half of eight samples follow the trigger
        for (int r = 1; r < 5; r++) begin
            setCfg(1'b0, r[3:0]);
            fire(0, 1'b1, ok);
            tl = ((r == 3) ? `DR_T10_MS : `DR_T20_MS) * CLK_KHZ;
            if (r > 2) chkV(n >= 3 * tl && n <= 5 * tl + 20, 1, "one-cycle rate");
        end
        $display("test rates done");
        conclude();
    end
endmodule // tb_dr_recorder
